// ---- hw/tmr3_defines.svh ----
// tmr3_defines.svh: register offsets, bit positions, reset values and counts
// assumes: an 8-bit register port and one clock at the oscillator rate
`ifndef TMR3_DEFINES_SVH
`define TMR3_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TMR3_OFF_CFG 8'h87
`define TMR3_OFF_RUN 8'h88
`define TMR3_OFF_MODE 8'h89
`define TMR3_OFF_LOW0 8'h8A
`define TMR3_OFF_LOW1 8'h8B
`define TMR3_OFF_HIGH0 8'h8C
`define TMR3_OFF_HIGH1 8'h8D
`define TMR3_OFF_T2CTL 8'hC8
`define TMR3_OFF_RLD_LO 8'hCA
`define TMR3_OFF_RLD_HI 8'hCB
`define TMR3_OFF_T2_LO 8'hCC
`define TMR3_OFF_T2_HI 8'hCD

// ----------------------------------------
// field positions
// ----------------------------------------
// mode register: timer 1 fields sit TMR3_T1_SHIFT above timer 0
`define TMR3_B_GATE 3
`define TMR3_B_CNT 2
`define TMR3_B_MODE_HI 1
`define TMR3_T1_SHIFT 4
// run register
`define TMR3_B_RUN0 4
`define TMR3_B_OVF0 5
`define TMR3_B_RUN1 6
`define TMR3_B_OVF1 7
// config register
`define TMR3_B_SIXCLK 0
`define TMR3_B_PDOWN 1
// timer 2 control
`define TMR3_B_T2OVF 7
`define TMR3_B_EXT 6
`define TMR3_B_RXSEL 5
`define TMR3_B_TXSEL 4
`define TMR3_B_EXEN 3
`define TMR3_B_T2RUN 2
`define TMR3_B_T2SRC 1
`define TMR3_B_CPRL 0

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define TMR3_RST_STATE '0
`define TMR3_RD_UNMAPPED 8'h00
`define TMR3_MC_12CLK 4'hC
`define TMR3_MC_6CLK 4'h6
`define TMR3_BAUD_LAST 4'hF
`define TMR3_PIN_W 6

`endif

// ---- hw/tmr3_pin_sync.sv ----
// tmr3_pin_sync: two-flop synchronisers and falling-edge detect for timer pins
// assumes: pins are asynchronous to clk; outputs feed same-clock logic
`timescale 1ns/100ps
`default_nettype none
`include "tmr3_defines.svh"

module tmr3_pin_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire tmr3_pkg::tmr3_pins_t pins_in,
	output var tmr3_pkg::tmr3_pins_t level,
	output var tmr3_pkg::tmr3_pins_t fall
);

	tmr3_pkg::tmr3_sync_t s;
	tmr3_pkg::tmr3_sync_t next_s;
	logic [`TMR3_PIN_W-1:0] fall_v;

	always_comb begin
		next_s = s;
		next_s.stage1 = pins_in;
		next_s.stage2 = s.stage1;
		next_s.stage3 = s.stage2;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= `TMR3_RST_STATE;
		end else begin
			s <= next_s;
		end
	end

	// stage1 is left alone: only stage2 onward is safe to decode
	genvar g;
	for (g = 0; g < `TMR3_PIN_W; g++) begin : g_edge
		assign fall_v[g] = s.stage3[g] & ~s.stage2[g];
	end

	assign level = s.stage2;
	assign fall = fall_v;

endmodule
`default_nettype wire

// ---- hw/tmr3_pkg.sv ----
// tmr3_pkg: types shared by the timer block and its pin synchroniser
// assumes: tmr3_defines.svh on the include path
`default_nettype none
`include "tmr3_defines.svh"

package tmr3_pkg;

	typedef enum logic [1:0] {
		TMR3_MODE_13BIT = 2'b00,
		TMR3_MODE_16BIT = 2'b01,
		TMR3_MODE_RELOAD8 = 2'b10,
		TMR3_MODE_SPLIT = 2'b11
	} tmr3_mode_t;

	typedef struct packed {
		logic [1:0] int_pin;
		logic [1:0] cnt_pin;
		logic t2_cnt;
		logic t2_trig;
	} tmr3_pins_t;

	typedef struct packed {
		logic [`TMR3_PIN_W-1:0] stage1;
		logic [`TMR3_PIN_W-1:0] stage2;
		logic [`TMR3_PIN_W-1:0] stage3;
	} tmr3_sync_t;

	typedef struct packed {
		logic [7:0] rdata;
		logic rx_pulse;
		logic tx_pulse;
		logic [3:0] mc_cnt;
		logic baud_div;
		logic [3:0] div16;
		logic six_clock;
		logic power_down;
		logic [1:0] run;
		logic [1:0] ovf;
		logic [7:0] mode_ctl;
		logic [1:0][7:0] low_byte;
		logic [1:0][7:0] high_byte;
		logic [7:0] t2_ctl;
		logic [15:0] t2_count;
		logic [15:0] t2_reload;
	} tmr3_state_t;

endpackage
`default_nettype wire

// ---- hw/tmr3_top.sv ----
// tmr3_top: timers 0, 1 and 2 with register port and serial clock selects
// assumes: one clock at the oscillator rate, strobes from same-clock logic
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "tmr3_defines.svh"

// How it works
// - gate set: count needs interrupt pin high
// - gate clear: count whenever run bit set
// - source bit picks internal clock or pin
// - mode 00: five-bit prescaler below high byte
// - mode 3: timer 0 low byte own controls
// - mode 3: timer 0 high uses timer 1 run
// - receive clock from timer 2 or 1
// - timer 2 counts only with run bit
// - timer 2 internal: one per machine cycle
// - timer 2 external: falling edges on pin
// - capture on trigger fall when enabled
// - reload select: reload on overflow, or enabled trigger fall
// - baud mode forces reload on overflow
// - external baud: overflow rate over sixteen
// - internal baud: oscillator over n times span
// - baud mode: trigger fall neither captures nor reloads
// - idle leaves every timer running
// - power-down freezes all counting, keeps state
module tmr3_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] ext_interrupt_pin,
	input wire logic [1:0] ext_count_pin,
	input wire logic t2_count_pin,
	input wire logic t2_trigger_pin,
	output logic rx_clk_pulse,
	output logic tx_clk_pulse
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	tmr3_pkg::tmr3_pins_t pins_raw;
	tmr3_pkg::tmr3_pins_t pin_lvl;
	tmr3_pkg::tmr3_pins_t pin_fall;

	assign pins_raw = {ext_interrupt_pin, ext_count_pin, t2_count_pin, t2_trigger_pin};

	tmr3_pin_sync u_sync (
		.clk(clk),
		.rstn(rstn),
		.pins_in(pins_raw),
		.level(pin_lvl),
		.fall(pin_fall)
	);

	// ----------------------------------------
	// state and step function
	// ----------------------------------------
	tmr3_pkg::tmr3_state_t s;
	tmr3_pkg::tmr3_state_t next_s;

	// returns {overflow, high, low}; mode 3 leaves the pair alone
	function automatic logic [16:0] tmr3_step(input logic [1:0] mode, input logic [7:0] hi,
		input logic [7:0] lo, input logic inc);
		logic [16:0] r;
		logic [5:0] lo6;
		logic [8:0] w9;
		r = {1'b0, hi, lo};
		lo6 = {1'b0, lo[4:0]} + 6'h01;
		w9 = {1'b0, hi} + 9'h001;
		if (inc) begin
			case (tmr3_pkg::tmr3_mode_t'(mode))
				tmr3_pkg::TMR3_MODE_13BIT: begin
					if (lo6[5]) begin
						r = {w9[8], w9[7:0], lo[7:5], lo6[4:0]};
					end else begin
						r = {1'b0, hi, lo[7:5], lo6[4:0]};
					end
				end
				tmr3_pkg::TMR3_MODE_16BIT: begin
					r = {1'b0, hi, lo} + 17'h00001;
				end
				tmr3_pkg::TMR3_MODE_RELOAD8: begin
					w9 = {1'b0, lo} + 9'h001;
					r = {w9[8], hi, w9[8] ? hi : w9[7:0]};
				end
				default: begin
					r = {1'b0, hi, lo};
				end
			endcase
		end
		return r;
	endfunction

	// ----------------------------------------
	// prescale and timers 0/1
	// ----------------------------------------
	logic pd;
	logic mc_tick;
	logic baud_tick;
	logic [1:0] gate_on;
	logic [1:0] tick;
	logic [1:0][16:0] step_res;
	logic split;
	logic split_hi_tick;
	logic [8:0] split_lo;
	logic [8:0] split_hi;
	logic t1_ovf;

	// only power-down stops the timers; idle is not seen here at all
	assign pd = s.power_down;
	// compare is >= so that a switch to six-clock mode with the count already
	// past the shorter end point wraps at once instead of running to 15
	assign mc_tick = (s.mc_cnt >= ((s.six_clock ? `TMR3_MC_6CLK : `TMR3_MC_12CLK) - 4'h1));
	// baud mode runs the counter at osc/2 (12-clock) or osc (6-clock)
	assign baud_tick = s.six_clock | s.baud_div;

	genvar g;
	for (g = 0; g < 2; g++) begin : g_tmr
		assign gate_on[g] = s.run[g] & ~pd
			& (~s.mode_ctl[4*g+`TMR3_B_GATE] | pin_lvl.int_pin[g]);
		assign tick[g] = gate_on[g]
			& (s.mode_ctl[4*g+`TMR3_B_CNT] ? pin_fall.cnt_pin[g] : mc_tick);
		assign step_res[g] = tmr3_step(s.mode_ctl[4*g+`TMR3_B_MODE_HI -: 2], s.high_byte[g],
			s.low_byte[g], tick[g]);
	end

	assign split = (s.mode_ctl[`TMR3_B_MODE_HI -: 2] == tmr3_pkg::TMR3_MODE_SPLIT);
	assign split_lo = {1'b0, s.low_byte[0]} + {8'h00, tick[0]};
	assign split_hi_tick = s.run[1] & mc_tick & ~pd;
	assign split_hi = {1'b0, s.high_byte[0]} + {8'h00, split_hi_tick};
	assign t1_ovf = step_res[1][16];

	// ----------------------------------------
	// timer 2
	// ----------------------------------------
	logic baud;
	logic cprl;
	logic t2_tick;
	logic [16:0] t2_inc;
	logic t2_ovf;
	logic trig_edge;
	logic cap;
	logic rel_ext;
	logic t2_baud;

	assign baud = s.t2_ctl[`TMR3_B_RXSEL] | s.t2_ctl[`TMR3_B_TXSEL];
	assign cprl = s.t2_ctl[`TMR3_B_CPRL];
	assign t2_tick = s.t2_ctl[`TMR3_B_T2RUN] & ~pd
		& (s.t2_ctl[`TMR3_B_T2SRC] ? pin_fall.t2_cnt
		: (baud ? baud_tick : mc_tick));
	assign t2_inc = {1'b0, s.t2_count} + 17'h00001;
	assign t2_ovf = t2_tick & t2_inc[16];
	assign trig_edge = pin_fall.t2_trig & s.t2_ctl[`TMR3_B_EXEN] & ~pd;
	assign cap = trig_edge & cprl & ~baud;
	assign rel_ext = trig_edge & ~cprl & ~baud;
	// every sixteenth overflow is one serial clock, whatever drives the counter
	assign t2_baud = t2_ovf & baud & (s.div16 == `TMR3_BAUD_LAST);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic [1:0] ovf_set;
	logic t2ovf_set;

	always_comb begin
		next_s = s;
		ovf_set = 2'b00;
		t2ovf_set = t2_ovf & ~baud;
		next_s.rdata = `TMR3_RD_UNMAPPED;
		if (!pd) begin
			next_s.mc_cnt = mc_tick ? 4'h0 : s.mc_cnt + 4'h1;
			next_s.baud_div = ~s.baud_div;
		end
		if (split) begin
			next_s.low_byte[0] = split_lo[7:0];
			next_s.high_byte[0] = split_hi[7:0];
			ovf_set = {split_hi[8], split_lo[8]};
		end else begin
			next_s.high_byte[0] = step_res[0][15:8];
			next_s.low_byte[0] = step_res[0][7:0];
			ovf_set[0] = step_res[0][16];
			ovf_set[1] = t1_ovf;
		end
		next_s.high_byte[1] = step_res[1][15:8];
		next_s.low_byte[1] = step_res[1][7:0];
		if (rel_ext) begin
			next_s.t2_count = s.t2_reload;
		end else if (t2_ovf && (baud || !cprl)) begin
			next_s.t2_count = s.t2_reload;
		end else if (t2_tick) begin
			next_s.t2_count = t2_inc[15:0];
		end
		if (cap) begin
			next_s.t2_reload = s.t2_count;
		end
		if (t2_ovf && baud) begin
			next_s.div16 = s.div16 + 4'h1;
		end
		next_s.rx_pulse = s.t2_ctl[`TMR3_B_RXSEL] ? t2_baud : t1_ovf;
		next_s.tx_pulse = s.t2_ctl[`TMR3_B_TXSEL] ? t2_baud : t1_ovf;
		if (reg_wr) begin
			case (reg_addr)
				`TMR3_OFF_CFG: begin
					next_s.six_clock = reg_wdata[`TMR3_B_SIXCLK];
					next_s.power_down = reg_wdata[`TMR3_B_PDOWN];
				end
				`TMR3_OFF_RUN: begin
					next_s.run[0] = reg_wdata[`TMR3_B_RUN0];
					next_s.ovf[0] = reg_wdata[`TMR3_B_OVF0];
					next_s.run[1] = reg_wdata[`TMR3_B_RUN1];
					next_s.ovf[1] = reg_wdata[`TMR3_B_OVF1];
				end
				`TMR3_OFF_MODE: next_s.mode_ctl = reg_wdata;
				`TMR3_OFF_LOW0: next_s.low_byte[0] = reg_wdata;
				`TMR3_OFF_LOW1: next_s.low_byte[1] = reg_wdata;
				`TMR3_OFF_HIGH0: next_s.high_byte[0] = reg_wdata;
				`TMR3_OFF_HIGH1: next_s.high_byte[1] = reg_wdata;
				`TMR3_OFF_T2CTL: next_s.t2_ctl = reg_wdata;
				`TMR3_OFF_RLD_LO: next_s.t2_reload[7:0] = reg_wdata;
				`TMR3_OFF_RLD_HI: next_s.t2_reload[15:8] = reg_wdata;
				`TMR3_OFF_T2_LO: next_s.t2_count[7:0] = reg_wdata;
				`TMR3_OFF_T2_HI: next_s.t2_count[15:8] = reg_wdata;
				default: begin
				end
			endcase
		end
		// hardware set wins over a software clear in the same cycle
		next_s.ovf = next_s.ovf | ovf_set;
		next_s.t2_ctl[`TMR3_B_T2OVF] = next_s.t2_ctl[`TMR3_B_T2OVF] | t2ovf_set;
		next_s.t2_ctl[`TMR3_B_EXT] = next_s.t2_ctl[`TMR3_B_EXT] | trig_edge;
		if (reg_rd) begin
			case (reg_addr)
				`TMR3_OFF_CFG: next_s.rdata = {6'h00, s.power_down, s.six_clock};
				`TMR3_OFF_RUN: next_s.rdata = {s.ovf[1], s.run[1], s.ovf[0], s.run[0], 4'h0};
				`TMR3_OFF_MODE: next_s.rdata = s.mode_ctl;
				`TMR3_OFF_LOW0: next_s.rdata = s.low_byte[0];
				`TMR3_OFF_LOW1: next_s.rdata = s.low_byte[1];
				`TMR3_OFF_HIGH0: next_s.rdata = s.high_byte[0];
				`TMR3_OFF_HIGH1: next_s.rdata = s.high_byte[1];
				`TMR3_OFF_T2CTL: next_s.rdata = s.t2_ctl;
				`TMR3_OFF_RLD_LO: next_s.rdata = s.t2_reload[7:0];
				`TMR3_OFF_RLD_HI: next_s.rdata = s.t2_reload[15:8];
				`TMR3_OFF_T2_LO: next_s.rdata = s.t2_count[7:0];
				`TMR3_OFF_T2_HI: next_s.rdata = s.t2_count[15:8];
				default: next_s.rdata = `TMR3_RD_UNMAPPED;
			endcase
		end
	end

	// power-down keeps every stored value; only the counting stops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= `TMR3_RST_STATE;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign rx_clk_pulse = s.rx_pulse;
	assign tx_clk_pulse = s.tx_pulse;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence seq_capture_edge;
		trig_edge && cprl && !baud && !reg_wr;
	endsequence

	sequence seq_capture_done;
		(s.t2_reload == $past(s.t2_count)) && s.t2_ctl[`TMR3_B_EXT];
	endsequence

	sequence seq_last_baud_ovf;
		baud && t2_ovf && (s.div16 == `TMR3_BAUD_LAST) && s.t2_ctl[`TMR3_B_RXSEL];
	endsequence

	chk_gate_blocks: assert property (
		(s.mode_ctl[`TMR3_B_GATE] && !pin_lvl.int_pin[0] && !reg_wr) |=> $stable(s.low_byte[0]))
		else $error("timer 0 moved with gate set and pin low");

	chk_free_run: assert property (
		(s.run[0] && !s.mode_ctl[`TMR3_B_GATE] && !s.mode_ctl[`TMR3_B_CNT] && !pd && mc_tick
		&& s.mode_ctl[`TMR3_B_MODE_HI -: 2] == 2'h1 && !reg_wr)
		|=> ({s.high_byte[0], s.low_byte[0]} == $past({s.high_byte[0], s.low_byte[0]}) + 16'h0001))
		else $error("timer 0 missed a machine cycle");

	chk_prescale_carry: assert property (
		(s.mode_ctl[`TMR3_B_MODE_HI+4 -: 2] == 2'h0 && tick[1] && s.low_byte[1][4:0] == 5'h1F
		&& !reg_wr)
		|=> (s.low_byte[1][4:0] == 5'h00 && s.high_byte[1] == $past(s.high_byte[1]) + 8'h01))
		else $error("prescaler carry not passed to high byte");

	chk_byte_reload: assert property (
		(s.mode_ctl[`TMR3_B_MODE_HI+4 -: 2] == 2'h2 && tick[1] && s.low_byte[1] == 8'hFF && !reg_wr)
		|=> (s.low_byte[1] == $past(s.high_byte[1])))
		else $error("low byte not reloaded from high byte");

	chk_t1_frozen: assert property (
		(s.mode_ctl[`TMR3_B_MODE_HI+4 -: 2] == 2'h3 && !reg_wr)
		|=> $stable({s.high_byte[1], s.low_byte[1]}))
		else $error("timer 1 moved in mode 3");

	chk_t2_stopped: assert property (
		(!s.t2_ctl[`TMR3_B_T2RUN] && !trig_edge && !reg_wr) |=> $stable(s.t2_count))
		else $error("timer 2 moved while stopped");

	chk_capture: assert property (
		seq_capture_edge |=> seq_capture_done)
		else $error("capture edge did not latch count");

	chk_no_flag_baud: assert property (
		(baud && !s.t2_ctl[`TMR3_B_T2OVF] && !reg_wr) |=> !s.t2_ctl[`TMR3_B_T2OVF])
		else $error("overflow flag set in baud mode");

	chk_baud_out: assert property (
		// the serial clock follows the sixteenth overflow by one register stage
		seq_last_baud_ovf |=> rx_clk_pulse)
		else $error("sixteenth overflow gave no receive clock");

	chk_baud_trig: assert property (
		(baud && pin_fall.t2_trig && !t2_ovf && !reg_wr) |=> $stable(s.t2_reload))
		else $error("trigger edge acted in baud mode");

	chk_pd_freeze: assert property (
		(pd && !reg_wr) |=> $stable(s.t2_count) && $stable(s.low_byte) && $stable(s.high_byte))
		else $error("counting during power-down");

endmodule
`default_nettype wire

// ---- testbench/timer_counters_zero_one_two_tb_top.sv ----
// timer_counters_zero_one_two_tb_top: directed scenarios for tmr3_top
// assumes: tmr3_far_model drives the pins and counts serial clocks
`timescale 1ns/100ps
`default_nettype none

module timer_counters_zero_one_two_tb_top;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic clk;
	logic rstn;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [1:0] ext_interrupt_pin;
	logic [1:0] ext_count_pin;
	logic t2_count_pin;
	logic t2_trigger_pin;
	logic rx_clk_pulse;
	logic tx_clk_pulse;
	int check_count = 0;
	int miscompares = 0;

	tmr3_top dut_u (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.ext_interrupt_pin, .ext_count_pin, .t2_count_pin, .t2_trigger_pin,
		.rx_clk_pulse, .tx_clk_pulse);
	tmr3_far_model far_u (.clk, .rx_clk_pulse, .tx_clk_pulse, .ext_interrupt_pin,
		.ext_count_pin, .t2_count_pin, .t2_trigger_pin);

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cmpw(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
		check_count++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
		end
	endtask

	task automatic chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		cmp({8'h00, d}, {8'h00, e});
	endtask

	task automatic t2_load(input logic [15:0] rl, input logic [15:0] cnt);
		wr(8'hCA, rl[7:0]);
		wr(8'hCB, rl[15:8]);
		wr(8'hCC, cnt[7:0]);
		wr(8'hCD, cnt[15:8]);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		chk(8'h89, 8'h00);
		chk(8'hC8, 8'h00);
		chk(8'h00, 8'h00);
		wr(8'h00, 8'hFF);
		wr(8'h89, 8'hA5);
		chk(8'h89, 8'hA5);
		chk(8'h00, 8'h00);
	endtask

	task automatic t_gate();
		logic [7:0] d;
		wr(8'h89, 8'h0D);
		wr(8'h8A, 8'hFE);
		wr(8'h8C, 8'h00);
		wr(8'h88, 8'h10);
		far_u.set_int(2'h2);
		far_u.pulse(0, 3);
		chk(8'h8A, 8'hFE);
		far_u.set_int(2'h3);
		far_u.pulse(0, 3);
		chk(8'h8A, 8'h01);
		chk(8'h8C, 8'h01);
		wr(8'h89, 8'h05);
		far_u.set_int(2'h0);
		far_u.pulse(0, 1);
		chk(8'h8A, 8'h02);
		wr(8'h87, 8'h02);
		far_u.pulse(0, 2);
		chk(8'h8A, 8'h02);
		wr(8'h87, 8'h00);
		// internal source in mode 01: one step per twelve clocks
		wr(8'h89, 8'h01);
		wr(8'h8C, 8'h00);
		wr(8'h8A, 8'h00);
		repeat (120) @(posedge clk);
		rd(8'h8A, d);
		cmpw({8'h00, d}, 16'h0009, 16'h000B);
		wr(8'h88, 8'h00);
	endtask

	task automatic t_modes();
		wr(8'h89, 8'h40);
		wr(8'h8B, 8'hFF);
		wr(8'h8D, 8'h05);
		wr(8'h88, 8'h40);
		far_u.pulse(1, 1);
		chk(8'h8B, 8'hE0);
		chk(8'h8D, 8'h06);
		wr(8'h89, 8'h06);
		wr(8'h8C, 8'hF0);
		wr(8'h8A, 8'hFF);
		wr(8'h88, 8'h10);
		far_u.pulse(0, 2);
		chk(8'h8A, 8'hF1);
		chk(8'h88, 8'h30);
	endtask

	task automatic t_split();
		logic [7:0] d;
		wr(8'h89, 8'h77);
		wr(8'h8A, 8'h00);
		wr(8'h8B, 8'h33);
		wr(8'h88, 8'h50);
		far_u.pulse(0, 2);
		far_u.pulse(1, 2);
		chk(8'h8A, 8'h02);
		chk(8'h8B, 8'h33);
		wr(8'h8C, 8'h00);
		repeat (120) @(posedge clk);
		rd(8'h8C, d);
		cmpw({8'h00, d}, 16'h0009, 16'h000B);
		wr(8'h88, 8'h00);
	endtask

	task automatic t_serial();
		int r0;
		int x0;
		logic [15:0] e0;
		t2_load(16'hFFFF, 16'hFFFF);
		wr(8'hC8, 8'h36);
		r0 = far_u.rx_seen;
		x0 = far_u.tx_seen;
		far_u.pulse(2, 16);
		cmp(16'(far_u.rx_seen - r0), 16'h0001);
		cmp(16'(far_u.tx_seen - x0), 16'h0001);
		chk(8'hC8, 8'h36);
		wr(8'hC8, 8'h3E);
		wr(8'hCC, 8'h34);
		far_u.pulse(3, 1);
		chk(8'hCC, 8'h34);
		chk(8'hCA, 8'hFF);
		// capture select set: baud mode must still reload on overflow
		t2_load(16'hFFF0, 16'hFFFF);
		wr(8'hC8, 8'h37);
		far_u.pulse(2, 1);
		chk(8'hCC, 8'hF0);
		chk(8'hC8, 8'h37);
		// internal baud, reload FFFE: 64 clocks per serial clock, 32 in six-clock mode
		for (int m = 0; m < 2; m++) begin
			wr(8'h87, m[7:0]);
			t2_load(16'hFFFE, 16'hFFFE);
			wr(8'hC8, 8'h34);
			r0 = far_u.rx_seen;
			e0 = 16'h0004 + 16'(5 * m);
			repeat (320) @(posedge clk);
			cmpw(16'(far_u.rx_seen - r0), e0, e0 + 16'h0002);
		end
		wr(8'hC8, 8'h00);
		wr(8'h87, 8'h00);
		wr(8'h89, 8'h60);
		wr(8'h8B, 8'hFF);
		wr(8'h8D, 8'hFF);
		wr(8'h88, 8'h40);
		r0 = far_u.rx_seen;
		x0 = far_u.tx_seen;
		far_u.pulse(1, 2);
		cmp(16'(far_u.rx_seen - r0), 16'h0002);
		cmp(16'(far_u.tx_seen - x0), 16'h0002);
		wr(8'h88, 8'h00);
	endtask

	task automatic t_t2();
		logic [7:0] d;
		t2_load(16'h0000, 16'h0000);
		wr(8'hC8, 8'h0B);
		far_u.pulse(2, 2);
		chk(8'hCC, 8'h00);
		wr(8'hC8, 8'h0F);
		far_u.pulse(2, 3);
		chk(8'hCC, 8'h03);
		far_u.pulse(3, 1);
		chk(8'hCA, 8'h03);
		chk(8'hC8, 8'h4F);
		t2_load(16'hFFFE, 16'hFFFF);
		wr(8'hC8, 8'h06);
		far_u.pulse(2, 1);
		chk(8'hCC, 8'hFE);
		chk(8'hC8, 8'h86);
		wr(8'hC8, 8'h0E);
		wr(8'hCC, 8'h00);
		far_u.pulse(3, 1);
		chk(8'hCC, 8'hFE);
		chk(8'hC8, 8'h4E);
		for (int m = 0; m < 2; m++) begin
			wr(8'h87, m[7:0]);
			t2_load(16'h0000, 16'h0000);
			wr(8'hC8, 8'h04);
			repeat (120) @(posedge clk);
			wr(8'hC8, 8'h00);
			rd(8'hCC, d);
			cmpw({8'h00, d}, 16'h0009 + 16'(10 * m), 16'h000B + 16'(10 * m));
		end
		wr(8'h87, 8'h00);
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#100000;
		miscompares++;
		close_out();
	end

	initial begin
		rstn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_gate();
		t_modes();
		t_split();
		t_serial();
		t_t2();
		close_out();
	end
endmodule
`default_nettype wire

// ---- testbench/tmr3_far_model.sv ----
// tmr3_far_model: timer pin drivers and serial port pulse counter
// assumes: the bench calls pulse() and set_int(); pins idle high
`timescale 1ns/100ps
`default_nettype none

module tmr3_far_model (
	input wire logic clk,
	input wire logic rx_clk_pulse,
	input wire logic tx_clk_pulse,
	output var logic [1:0] ext_interrupt_pin,
	output var logic [1:0] ext_count_pin,
	output var logic t2_count_pin,
	output var logic t2_trigger_pin
);
	// ----------------------------------------
	// pins and serial side
	// ----------------------------------------
	int rx_seen = 0;
	int tx_seen = 0;

	initial begin
		ext_interrupt_pin = 2'h3;
		ext_count_pin = 2'h3;
		t2_count_pin = 1'b1;
		t2_trigger_pin = 1'b1;
	end

	always @(posedge clk) begin
		if (rx_clk_pulse === 1'b1)
			rx_seen <= rx_seen + 1;
		if (tx_clk_pulse === 1'b1)
			tx_seen <= tx_seen + 1;
	end

	task automatic drive(input int sel, input logic v);
		case (sel)
			0: ext_count_pin[0] <= v;
			1: ext_count_pin[1] <= v;
			2: t2_count_pin <= v;
			default: t2_trigger_pin <= v;
		endcase
	endtask

	task automatic set_int(input logic [1:0] v);
		@(posedge clk);
		ext_interrupt_pin <= v;
	endtask

	// 3 low, 3 high: above the two-clock minimum the synchronisers need
	task automatic pulse(input int sel, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			drive(sel, 1'b0);
			repeat (3) @(posedge clk);
			drive(sel, 1'b1);
			repeat (2) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask
endmodule
`default_nettype wire
